// ==== usb_mouse_enum.sv ====
// Device-side attach, enumeration and endpoint 1 report control
// Contract
// R1 - A setting chooses engine or firmware direct control of D+ and D-.
// R2 - After attach, ignore all bus traffic until the first bus reset.
// R3 - Pull up D- to announce low speed; signal at 1.5 Mbps.
// R4 - Host drives bus reset before any configuration traffic.
// R5 - Answer SETUP descriptor requests; host then assigns a unique address.
// R6 - After addressing answer only the new address; keep serving descriptors.
// R7 - Descriptors report two data endpoints.
// R8 - Send endpoint 1 data only when configured and new data exists.
// R9 - Accept reset or reconfiguration anytime and restart the sequence.
// R10 - Endpoint 0 is the default control channel from power-up.
// R11 - When idle, answer endpoint 1 IN with NAK.
// R12 - Store a new address; apply it after the status stage.
// R13 - Boot reports are three bytes; report protocol adds wheel byte four.
// R14 - Bus reset returns default address and disables endpoint 1.
// R15 - Hold pending motion and buttons until reports can be sent.
module usb_mouse_enum
   import usb_mouse_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        fw_pin_ctrl_i,
   input  wire logic        fw_dp_i,
   input  wire logic        fw_dm_i,
   input  wire logic        fw_oe_i,
   input  wire logic        sie_dp_i,
   input  wire logic        sie_dm_i,
   input  wire logic        sie_oe_i,
   input  wire logic        dp_i,
   input  wire logic        dm_i,
   output logic             dp_o,
   output logic             dm_o,
   output logic             dp_oe_o,
   output logic             dm_oe_o,
   output logic             dm_pullup_o,
   output logic             bit_stb_o,
   input  wire logic        bus_reset_i,
   input  wire logic        tok_valid_i,
   input  wire logic [1:0]  tok_pid_i,
   input  wire logic [6:0]  tok_addr_i,
   input  wire logic [3:0]  tok_ep_i,
   input  wire logic [7:0]  setup_req_i,
   input  wire logic [7:0]  setup_val_i,
   input  wire logic        status_done_i,
   output logic             tok_accept_o,
   output logic [1:0]       hs_o,
   output logic [3:0]       hs_ep_o,
   output logic [31:0]      tx_data_o,
   output logic [2:0]       tx_len_o,
   output logic [7:0]       num_data_ep_o,
   output logic [6:0]       dev_addr_o,
   output logic             configured_o,
   output logic             boot_proto_o,
   input  wire logic        mot_valid_i,
   input  wire logic [7:0]  mot_btn_i,
   input  wire logic [7:0]  mot_dx_i,
   input  wire logic [7:0]  mot_dy_i,
   input  wire logic [7:0]  mot_dz_i,
   output logic             mot_ready_o
);
   // Token pid codes: 0 SETUP, 1 IN, 2 OUT
   localparam logic [1:0] PID_SETUP = 2'h0;
   localparam logic [1:0] PID_IN    = 2'h1;

   dev_state_t  state_r;
   dev_state_t  state_nxt;
   logic [6:0]  addr_r;
   logic [6:0]  pend_addr_r;
   logic        boot_r;
   logic [1:0]  hs_r;
   logic [3:0]  hs_ep_r;
   logic [31:0] tx_r;
   logic [2:0]  len_r;
   logic [7:0]  bitcnt_r;
   logic        bit_r;
   logic [7:0]  acc_btn_r;
   logic [7:0]  acc_x_r;
   logic [7:0]  acc_y_r;
   logic [7:0]  acc_z_r;
   logic        acc_pend_r;
   logic [31:0] fifo_data;
   logic        fifo_valid;

   report_if rpt ();

   // Pin ownership select
   assign dp_o    = fw_pin_ctrl_i ? fw_dp_i : sie_dp_i;   // [R1]
   assign dm_o    = fw_pin_ctrl_i ? fw_dm_i : sie_dm_i;   // [R1]
   wire   drv_oe  = fw_pin_ctrl_i ? fw_oe_i : sie_oe_i;   // [R1]
   // Engine may only drive after the first bus reset
   wire   live    = (state_r != ST_ATTACH);
   assign dp_oe_o = drv_oe && (live || fw_pin_ctrl_i);    // [R2]
   assign dm_oe_o = dp_oe_o;
   assign dm_pullup_o = 1'b1;                             // [R3]

   // Low-speed bit-time strobe
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bitcnt_r <= '0;
         bit_r    <= 1'b0;
      end else if (bitcnt_r == 8'(BIT_CYC - 1)) begin
         bitcnt_r <= '0;
         bit_r    <= 1'b1;                                // [R3]
      end else begin
         bitcnt_r <= bitcnt_r + 8'h01;
         bit_r    <= 1'b0;
      end
   end
   assign bit_stb_o = bit_r;

   // Address match, endpoint 0 usable after the first bus reset, endpoint 1 once configured
   wire addr_hit = live && (tok_addr_i == addr_r);        // [R6]
   wire ep0_hit  = addr_hit && (tok_ep_i == EP_CTRL);     // [R10]
   wire ep1_hit  = addr_hit && (tok_ep_i == EP_DATA) &&
                   (state_r == ST_CONFIG);                // [R8]
   wire take     = tok_valid_i && (ep0_hit || ep1_hit) &&
                   !bus_reset_i;
   assign tok_accept_o = take;

   wire is_setup = take && ep0_hit && (tok_pid_i == PID_SETUP);
   wire set_addr = is_setup && (setup_req_i == REQ_SET_ADDR);
   wire set_cfg  = is_setup && (setup_req_i == REQ_SET_CONFIG);
   wire set_prot = is_setup && (setup_req_i == REQ_SET_PROTO);
   wire ep1_in   = take && ep1_hit && (tok_pid_i == PID_IN);
   wire ep1_pop  = ep1_in && fifo_valid;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_ATTACH: begin
            if (bus_reset_i) state_nxt = ST_DEFAULT;     // [R2]
         end
         ST_DEFAULT: begin
            if (set_addr) state_nxt = ST_ADDRPND;        // [R5]
         end
         ST_ADDRPND: begin
            if (status_done_i) begin
               state_nxt = (pend_addr_r == DEFAULT_ADDR) ?
                           ST_DEFAULT : ST_ADDRESS;      // [R12]
            end
         end
         ST_ADDRESS: begin
            if (set_addr) state_nxt = ST_ADDRPND;
            else if (set_cfg && setup_val_i != 8'h00)
               state_nxt = ST_CONFIG;
         end
         ST_CONFIG: begin
            if (set_cfg && setup_val_i == 8'h00)
               state_nxt = ST_ADDRESS;                   // [R9]
            else if (set_addr) state_nxt = ST_ADDRPND;
         end
      endcase
      if (bus_reset_i && state_r != ST_ATTACH)
         state_nxt = ST_DEFAULT;                         // [R9]
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r     <= ST_ATTACH;
         addr_r      <= DEFAULT_ADDR;
         pend_addr_r <= DEFAULT_ADDR;
         boot_r      <= 1'b1;
      end else begin
         state_r <= state_nxt;
         if (bus_reset_i) begin
            addr_r <= DEFAULT_ADDR;                      // [R14]
            boot_r <= 1'b1;
         end else begin
            if (set_addr) pend_addr_r <= setup_val_i[6:0]; // [R12]
            if (state_r == ST_ADDRPND && status_done_i)
               addr_r <= pend_addr_r;                    // [R12]
            if (set_prot) boot_r <= (setup_val_i == 8'h00); // [R13]
         end
      end
   end

   // Handshake and data answer registered one cycle after the token
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         hs_r    <= HS_NONE;
         hs_ep_r <= 4'h0;
         tx_r    <= '0;
         len_r   <= 3'h0;
      end else if (!take) begin
         hs_r    <= HS_NONE;
      end else begin
         hs_ep_r <= tok_ep_i;
         if (ep1_in && !fifo_valid) begin
            hs_r <= HS_NAK;                              // [R11]
         end else if (ep1_in) begin
            hs_r  <= HS_DATA;                            // [R8]
            tx_r  <= boot_r ? {8'h00, fifo_data[23:0]} : fifo_data;
            len_r <= boot_r ? BOOT_LEN : REPORT_LEN;     // [R13]
         end else if (tok_pid_i == PID_IN) begin
            hs_r  <= HS_DATA;                            // [R5]
            tx_r  <= {24'h0, NUM_DATA_EP};               // [R7]
            len_r <= 3'h1;
         end else begin
            hs_r <= HS_ACK;                              // [R5]
         end
      end
   end

   // Motion accumulator: merges deltas while the FIFO is stalled
   wire acc_push = acc_pend_r && rpt.ready &&
                   (state_r == ST_CONFIG);
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_btn_r  <= 8'h00;
         acc_x_r    <= 8'h00;
         acc_y_r    <= 8'h00;
         acc_z_r    <= 8'h00;
         acc_pend_r <= 1'b0;
      end else if (mot_valid_i) begin
         acc_btn_r  <= mot_btn_i;
         acc_x_r    <= (acc_push ? 8'h00 : acc_x_r) + mot_dx_i; // [R15]
         acc_y_r    <= (acc_push ? 8'h00 : acc_y_r) + mot_dy_i; // [R15]
         acc_z_r    <= (acc_push ? 8'h00 : acc_z_r) + mot_dz_i; // [R15]
         acc_pend_r <= 1'b1;
      end else if (acc_push) begin
         acc_x_r    <= 8'h00;
         acc_y_r    <= 8'h00;
         acc_z_r    <= 8'h00;
         acc_pend_r <= 1'b0;
      end
   end
   assign mot_ready_o = 1'b1;
   assign rpt.data  = {acc_z_r, acc_y_r, acc_x_r, acc_btn_r};
   assign rpt.valid = acc_push;

   report_fifo #(
      .W (FIFO_W),
      .D (FIFO_D)
   ) u_fifo (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .in_s        (rpt),
      .out_data_o  (fifo_data),
      .out_valid_o (fifo_valid),
      .out_ready_i (ep1_pop),
      .flush_i     (bus_reset_i)                         // [R14]
   );

   assign hs_o          = hs_r;
   assign hs_ep_o       = hs_ep_r;
   assign tx_data_o     = tx_r;
   assign tx_len_o      = len_r;
   assign num_data_ep_o = NUM_DATA_EP;                   // [R7]
   assign dev_addr_o    = addr_r;
   assign configured_o  = (state_r == ST_CONFIG);
   assign boot_proto_o  = boot_r;
endmodule

// ==== usb_mouse_pkg.sv ====
// Shared constants and types for the low-speed mouse attach and enumeration
package usb_mouse_pkg;
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned LS_BIT_HZ       = 1_500_000;
   localparam int unsigned BIT_CYC         = CLK_HZ / LS_BIT_HZ;
   localparam logic [6:0]  DEFAULT_ADDR    = 7'h00;
   localparam logic [3:0]  EP_CTRL         = 4'h0;
   localparam logic [3:0]  EP_DATA         = 4'h1;
   localparam logic [7:0]  NUM_DATA_EP     = 8'h02;
   localparam logic [7:0]  REQ_GET_DESC    = 8'h06;
   localparam logic [7:0]  REQ_SET_ADDR    = 8'h05;
   localparam logic [7:0]  REQ_SET_CONFIG  = 8'h09;
   localparam logic [7:0]  REQ_SET_PROTO   = 8'h0b;
   localparam logic [2:0]  BOOT_LEN        = 3'h3;
   localparam logic [2:0]  REPORT_LEN      = 3'h4;
   localparam int unsigned FIFO_W          = 32;
   localparam int unsigned FIFO_D          = 16;
   localparam logic [1:0]  HS_ACK          = 2'h0;
   localparam logic [1:0]  HS_NAK          = 2'h1;
   localparam logic [1:0]  HS_DATA         = 2'h2;
   localparam logic [1:0]  HS_NONE         = 2'h3;

   typedef enum logic [4:0] {
      ST_ATTACH  = 5'b00001,
      ST_DEFAULT = 5'b00010,
      ST_ADDRPND = 5'b00100,
      ST_ADDRESS = 5'b01000,
      ST_CONFIG  = 5'b10000
   } dev_state_t;
endpackage

// ==== report_if.sv ====
// Report stream carrier between the motion collector and the report FIFO
interface report_if;
   logic [31:0] data;
   logic        valid;
   logic        ready;
   modport src  (output data, output valid, input ready);
   modport sink (input data, input valid, output ready);
endinterface

// ==== report_fifo.sv ====
// Parameterised FIFO holding pending reports
module report_fifo #(
   parameter int unsigned W = 32,
   parameter int unsigned D = 16
) (
   input  wire logic         core_clk_i,
   input  wire logic         rst_i,
   report_if.sink            in_s,
   output logic [W-1:0]      out_data_o,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   input  wire logic         flush_i
);
   localparam int unsigned AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wr_r;
   logic [AW:0]  rd_r;
   wire          full  = (wr_r[AW] != rd_r[AW]) &&
                         (wr_r[AW-1:0] == rd_r[AW-1:0]);
   wire          empty = (wr_r == rd_r);
   wire          push  = in_s.valid && !full;
   wire          pop   = out_ready_i && !empty;

   assign in_s.ready  = !full;
   assign out_valid_o = !empty;
   assign out_data_o  = mem[rd_r[AW-1:0]];

   always_ff @(posedge core_clk_i) begin
      if (push) begin
         mem[wr_r[AW-1:0]] <= in_s.data;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_r <= '0;
         rd_r <= '0;
      end else if (flush_i) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) wr_r <= wr_r + 1'b1;
         if (pop)  rd_r <= rd_r + 1'b1;
      end
   end
endmodule

// ==== usb_mouse_enum_assertions.sv ====
// Port-level assertions for the mouse enumeration block
module usb_mouse_enum_checker
   import usb_mouse_pkg::*;
(
   input wire logic       core_clk_i,
   input wire logic       rst_i,
   input wire logic       fw_pin_ctrl_i,
   input wire logic       fw_dp_i,
   input wire logic       fw_oe_i,
   input wire logic       dp_o,
   input wire logic       dp_oe_o,
   input wire logic       dm_pullup_o,
   input wire logic       bit_stb_o,
   input wire logic       bus_reset_i,
   input wire logic [6:0] tok_addr_i,
   input wire logic [3:0] tok_ep_i,
   input wire logic       tok_accept_o,
   input wire logic [1:0] hs_o,
   input wire logic [3:0] hs_ep_o,
   input wire logic [2:0] tx_len_o,
   input wire logic [7:0] num_data_ep_o,
   input wire logic [6:0] dev_addr_o,
   input wire logic       configured_o,
   input wire logic       boot_proto_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   pin_owner_a: assert property (
      fw_pin_ctrl_i |-> dp_o == fw_dp_i && dp_oe_o == fw_oe_i)
      else $error("firmware pin values not passed");
   const_outs_a: assert property (
      dm_pullup_o && num_data_ep_o == NUM_DATA_EP)
      else $error("pull-up or endpoint count wrong");
   bit_gap_a: assert property (
      bit_stb_o |=> !bit_stb_o [*8])
      else $error("bit strobe too frequent");
   addr_match_a: assert property (
      tok_accept_o |-> tok_addr_i == dev_addr_o && !bus_reset_i)
      else $error("token taken at foreign address");
   ep1_gate_a: assert property (
      tok_ep_i == EP_DATA && !configured_o |-> !tok_accept_o)
      else $error("data endpoint taken unconfigured");
   answer_next_a: assert property (
      tok_accept_o |=> hs_o != HS_NONE && hs_ep_o == $past(tok_ep_i))
      else $error("taken token not answered");
   no_answer_a: assert property (
      !tok_accept_o |=> hs_o == HS_NONE)
      else $error("answer without taken token");
   reset_clear_a: assert property (
      bus_reset_i |=> dev_addr_o == DEFAULT_ADDR && !configured_o)
      else $error("bus reset left address or config");
   rep_len_a: assert property (
      hs_o == HS_DATA && hs_ep_o == EP_DATA |->
      tx_len_o == (boot_proto_o ? BOOT_LEN : REPORT_LEN))
      else $error("report length wrong");
   cover property (hs_o == HS_DATA && hs_ep_o == EP_DATA);
   cover property (hs_o == HS_NAK);
   cover property (bus_reset_i && configured_o);
endmodule

bind usb_mouse_enum usb_mouse_enum_checker usb_mouse_enum_checker_i (
   .core_clk_i, .rst_i, .fw_pin_ctrl_i, .fw_dp_i, .fw_oe_i, .dp_o,
   .dp_oe_o, .dm_pullup_o, .bit_stb_o, .bus_reset_i, .tok_addr_i,
   .tok_ep_i, .tok_accept_o, .hs_o, .hs_ep_o, .tx_len_o, .num_data_ep_o,
   .dev_addr_o, .configured_o, .boot_proto_o);

// ==== usb_host_model.sv ====
// Host side model: bus reset, tokens, status stage and line levels
module usb_host_model (
   input  wire logic       core_clk_i,
   input  wire logic       tok_accept_i,
   input  wire logic [1:0] hs_i,
   input  wire logic       dp_drv_i,
   input  wire logic       dm_drv_i,
   input  wire logic       dp_oe_i,
   input  wire logic       dm_oe_i,
   input  wire logic       pullup_i,
   output logic            dp_line_o,
   output logic            dm_line_o,
   output logic            bus_reset_o = 1'b0,
   output logic            tok_valid_o = 1'b0,
   output logic [1:0]      tok_pid_o = 2'h0,
   output logic [6:0]      tok_addr_o = 7'h00,
   output logic [3:0]      tok_ep_o = 4'h0,
   output logic [7:0]      setup_req_o = 8'h00,
   output logic [7:0]      setup_val_o = 8'h00,
   output logic            status_done_o = 1'b0
);
   timeunit 1ns;
   timeprecision 100ps;
   // Undriven D- rests at the pull-up, D+ at the host pull-down
   assign dp_line_o = dp_oe_i ? dp_drv_i : 1'b0;
   assign dm_line_o = dm_oe_i ? dm_drv_i : pullup_i;
   task automatic bus_reset();
      @(posedge core_clk_i);
      #1 bus_reset_o = 1'b1;
      repeat (4) @(posedge core_clk_i);
      #1 bus_reset_o = 1'b0;
   endtask
   task automatic status();
      @(posedge core_clk_i);
      #1 status_done_o = 1'b1;
      @(posedge core_clk_i);
      #1 status_done_o = 1'b0;
   endtask
   task automatic send_tok(input logic [1:0] pid, input logic [6:0] ad,
      input logic [3:0] ep, input logic [7:0] rq, input logic [7:0] vl,
      output logic acc, output logic [1:0] hs);
      @(posedge core_clk_i);
      #1 {tok_pid_o, tok_addr_o, tok_ep_o} = {pid, ad, ep};
      {setup_req_o, setup_val_o} = {rq, vl};
      tok_valid_o = 1'b1;
      #7 acc = tok_accept_i;
      @(posedge core_clk_i);
      #1 tok_valid_o = 1'b0;
      tok_addr_o = ~ad;
      setup_val_o = ~vl;
      hs = hs_i;
   endtask
endmodule

// ==== usb_mouse_enum_tb_top.sv ====
// Self-checking bench for the mouse attach and enumeration block
module usb_mouse_enum_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import usb_mouse_pkg::*;
   logic core_clk_i, rst_i, fw_pin_ctrl_i, fw_dp_i, fw_dm_i, fw_oe_i;
   logic sie_dp_i, sie_dm_i, sie_oe_i, dp_i, dm_i, dp_o, dm_o, dp_oe_o;
   logic dm_oe_o, dm_pullup_o, bit_stb_o, bus_reset_i, tok_valid_i;
   logic status_done_i, tok_accept_o, configured_o, boot_proto_o;
   logic mot_valid_i, mot_ready_o, acc;
   logic [1:0] tok_pid_i, hs_o, hs;
   logic [6:0] tok_addr_i, dev_addr_o, a;
   logic [3:0] tok_ep_i, hs_ep_o;
   logic [7:0] setup_req_i, setup_val_i, num_data_ep_o, sum;
   logic [7:0] mot_btn_i, mot_dx_i, mot_dy_i, mot_dz_i;
   logic [31:0] tx_data_o, r;
   logic [2:0] tx_len_o;
   int err_total, comparisons, seed;
   usb_mouse_enum usb_mouse_enum_i (.*);
   usb_host_model usb_host_model_i (.core_clk_i, .tok_accept_i(tok_accept_o),
      .hs_i(hs_o), .dp_drv_i(dp_o), .dm_drv_i(dm_o), .dp_oe_i(dp_oe_o),
      .dm_oe_i(dm_oe_o), .pullup_i(dm_pullup_o), .dp_line_o(dp_i),
      .dm_line_o(dm_i), .bus_reset_o(bus_reset_i), .tok_valid_o(tok_valid_i),
      .tok_pid_o(tok_pid_i), .tok_addr_o(tok_addr_i), .tok_ep_o(tok_ep_i),
      .setup_req_o(setup_req_i), .setup_val_o(setup_val_i),
      .status_done_o(status_done_i));
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic complete_run();
      if (err_total == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp, input string m);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task automatic tk(logic [1:0] p, logic [6:0] ad, logic [3:0] ep,
      logic [7:0] rq, logic [7:0] vl);
      usb_host_model_i.send_tok(p, ad, ep, rq, vl, acc, hs);
   endtask
   task automatic mov(logic [31:0] v);
      @(posedge core_clk_i);
      #1 {mot_dz_i, mot_dy_i, mot_dx_i, mot_btn_i} = v;
      mot_valid_i = 1'b1;
      @(posedge core_clk_i);
      #1 mot_valid_i = 1'b0;
      repeat (3) @(posedge core_clk_i);
   endtask
   function automatic logic [31:0] expect_word(logic [31:0] v, logic boot);
      return boot ? {8'h00, v[23:0]} : v;
   endfunction
   initial begin
      seed = 32'he0b5ddd3;
      {fw_pin_ctrl_i, fw_dp_i, fw_dm_i, fw_oe_i, mot_valid_i} = '0;
      {sie_dp_i, sie_dm_i, sie_oe_i, mot_btn_i, mot_dx_i} = '0;
      {mot_dy_i, mot_dz_i} = '0;
      rst_i = 1'b1;
      repeat (10) @(posedge core_clk_i);
      #1 rst_i = 1'b0;
      sie_oe_i = 1'b1;
      #1 chk({dp_oe_o, dm_oe_o}, 0, "drives before bus reset");
      tk(0, 0, EP_CTRL, REQ_GET_DESC, 1);
      chk(acc, 0, "token taken before bus reset");
      usb_host_model_i.bus_reset();
      tk(0, 0, EP_CTRL, REQ_GET_DESC, 1);
      chk(acc, 1, "setup refused");
      tk(1, 0, EP_CTRL, 0, 0);
      chk({hs, tx_data_o[7:0]}, {HS_DATA, NUM_DATA_EP}, "ep0 in");
      a = 7'(($random(seed) & 32'h7e) | 32'h1);
      tk(0, 0, EP_CTRL, REQ_SET_ADDR, {1'b0, a});
      tk(1, a, EP_CTRL, 0, 0);
      chk(acc, 0, "address applied early");
      usb_host_model_i.status();
      repeat (2) @(posedge core_clk_i);
      tk(1, 0, EP_CTRL, 0, 0);
      chk(acc, 0, "old address answered");
      tk(1, a, EP_DATA, 0, 0);
      chk(acc, 0, "ep1 taken unconfigured");
      tk(0, a, EP_CTRL, REQ_SET_CONFIG, 1);
      tk(1, a, EP_DATA, 0, 0);
      chk(hs, HS_NAK, "idle ep1");
      for (int p = 0; p < 2; p++) begin
         tk(0, a, EP_CTRL, REQ_SET_PROTO, 8'(p));
         repeat (4) begin
            r = $random(seed);
            mov(r);
            tk(1, a, EP_DATA, 0, 0);
            chk(hs, HS_DATA, "report missing");
            chk(tx_data_o, expect_word(r, p == 0), "report word");
         end
      end
      repeat (18) mov(32'h00000100);
      sum = 8'h00;
      hs = HS_DATA;
      for (int i = 0; i < 24 && hs == HS_DATA; i++) begin
         tk(1, a, EP_DATA, 0, 0);
         if (hs == HS_DATA) sum += tx_data_o[15:8];
      end
      chk({hs, sum}, {HS_NAK, 8'd18}, "motion lost or stuck");
      for (int i = 0; i < 8; i++) begin
         @(posedge core_clk_i);
         #1 {fw_pin_ctrl_i, fw_dp_i, fw_dm_i, sie_dm_i} = 4'($random(seed));
         #1 chk(dm_o, fw_pin_ctrl_i ? fw_dm_i : sie_dm_i, "pin mux");
      end
      usb_host_model_i.bus_reset();
      chk({dev_addr_o, configured_o, boot_proto_o}, 9'h001, "reset");
      tk(1, a, EP_DATA, 0, 0);
      chk(acc, 0, "old config survives reset");
      complete_run();
   end
   initial begin
      repeat (30000) @(posedge core_clk_i);
      err_total++;
      complete_run();
   end
endmodule
